/* hdl/isfg_top.sv */
// Ingress per-stream filter, stream gate and policing decision with Wishbone registers
`timescale 1ns/100ps
`include "isfg_defs.svh"
module isfg_top (
  input wire logic clk_i, // Core clock, 200 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte enables
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic frame_valid_i, // Frame descriptor valid
  output logic frame_ready_o, // Descriptor accepted
  input wire logic [2:0] frame_port_i, // Ingress port number
  input wire logic frame_cut_through_i, // Frame forwarded cut-through
  input wire logic frame_stream_hit_i, // Lookup found a filter handle
  input wire logic [4:0] frame_handle_i, // Stream handle from lookup
  input wire logic [2:0] frame_pcp_i, // VLAN priority code point
  input wire logic [13:0] frame_len_i, // Length from addresses to FCS
  input wire logic [31:0] port_schedule_timer_sec_i, // Port schedule timer seconds
  input wire logic [29:0] port_schedule_timer_ns_i, // Port schedule timer nanoseconds
  output logic verdict_valid_o, // Verdict pulse
  output logic verdict_pass_o, // Frame may be forwarded
  output logic [2:0] verdict_reason_o, // Drop cause
  output logic [2:0] verdict_tc_o, // Egress traffic class
  output logic verdict_meter_use_o, // Meter must police the frame
  output logic [2:0] verdict_meter_id_o // Meter to use
);
  localparam int NG = `ISFG_NUM_GATES;
  isfg_pkg::isfg_state_t state_reg, state_next;
  isfg_pkg::isfg_reason_t reason;
  isfg_pkg::isfg_filt_t filt_rd;
  isfg_pkg::isfg_gate_cfg_t gate_cfg_reg [NG];
  isfg_pkg::isfg_gcl_t gcl_reg [NG][`ISFG_NUM_GCL];
  isfg_pkg::isfg_gcl_t pend_gcl_reg [`ISFG_NUM_GCL];
  isfg_pkg::isfg_gcl_t cur_gcl;
  isfg_pkg::isfg_gate_cfg_t cur_cfg;
  logic [31:0] cycle_reg [NG];
  logic [31:0] pos_reg [NG];
  logic [31:0] ent_ns_reg [NG];
  logic [1:0] ent_reg [NG];
  logic [15:0] budget_reg [NG];
  logic [NG-1:0] run_reg, closed_reg, cyc_end, ent_adv, do_switch;
  logic [31:0] stg_f0_reg, stg_f1_reg, stg_num_reg, stg_den_reg, stg_ext_reg, stg_bs_reg, stg_bns_reg;
  logic [31:0] stg_gcl_reg [`ISFG_NUM_GCL][2];
  logic [7:0] stg_ctrl_reg;
  logic [3:0] gate_sel_reg, pend_gate_reg, gid;
  logic pend_reg;
  logic [31:0] pend_cycle_reg, pend_ext_reg, pend_bs_reg, pend_bns_reg;
  logic [31:0] blocked_reg, valid_reg, clear_mask, rd_mux;
  logic ack_reg, wr_stb, apply_stb, filt_wr, base_due;
  logic fr_ct_reg, fr_hit_reg;
  logic [2:0] fr_port_reg, fr_pcp_reg;
  logic [4:0] fr_handle_reg;
  logic [13:0] fr_len_reg;
  logic judge_en, matched, oversize, gate_on, sched, g_open, oct_short, charge, latch_close, block_set;
  logic [2:0] tc_sel;

  // Merge write data into a register under the byte enables
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        res[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Port timer has reached a second and nanosecond instant
  function automatic logic time_reached(input logic [31:0] bs, input logic [31:0] bns);
    return (port_schedule_timer_sec_i > bs) ||
      ((port_schedule_timer_sec_i == bs) && ({2'h0, port_schedule_timer_ns_i} >= bns));
  endfunction

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Classic Wishbone: one wait cycle, write at the acknowledged edge
  assign wb_ack_o = ack_reg;
  assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
  assign apply_stb = wr_stb && (wb_adr_i == `ISFG_OFS_GATE_APPLY) && wb_sel_i[0] && wb_dat_i[`ISFG_APPLY_BIT];
  assign filt_wr = wr_stb && (wb_adr_i == `ISFG_OFS_FILT_CMD) && wb_sel_i[1] && wb_dat_i[`ISFG_CMD_WRITE_BIT];
  assign clear_mask = (wr_stb && wb_adr_i == `ISFG_OFS_FILT_BLOCKED) ? merge(32'h0000_0000, wb_dat_i, wb_sel_i) : '0;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
      wb_dat_o <= rd_mux;
    end
  end

  // Read decode; unmapped offsets read zero
  always_comb
  begin
    rd_mux = '0;
    case (wb_adr_i)
      `ISFG_OFS_FILT_DATA0: rd_mux = stg_f0_reg;
      `ISFG_OFS_FILT_DATA1: rd_mux = stg_f1_reg;
      `ISFG_OFS_FILT_CMD: rd_mux = valid_reg;
      `ISFG_OFS_FILT_BLOCKED: rd_mux = blocked_reg;
      `ISFG_OFS_GATE_SEL: rd_mux = {28'h000_0000, gate_sel_reg};
      `ISFG_OFS_GATE_CTRL: rd_mux = {24'h00_0000, stg_ctrl_reg};
      `ISFG_OFS_GATE_CYC_NUM: rd_mux = stg_num_reg;
      `ISFG_OFS_GATE_CYC_DEN: rd_mux = stg_den_reg;
      `ISFG_OFS_GATE_CYC_EXT: rd_mux = stg_ext_reg;
      `ISFG_OFS_GATE_BASE_S: rd_mux = stg_bs_reg;
      `ISFG_OFS_GATE_BASE_NS: rd_mux = stg_bns_reg;
      `ISFG_OFS_GATE_APPLY: rd_mux = {closed_reg, 15'h0000, pend_reg};
      `ISFG_OFS_GATE_STATUS: rd_mux = {28'h000_0000, ent_reg[gate_sel_reg], closed_reg[gate_sel_reg],
        run_reg[gate_sel_reg]};
      default:
      begin
        if (wb_adr_i[7:5] == `ISFG_GCL_BASE_HI)
        begin
          rd_mux = stg_gcl_reg[wb_adr_i[4:3]][wb_adr_i[2]];
        end
      end
    endcase
  end

  // Staging registers for the filter table and the selected gate
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stg_f0_reg <= '0;
      stg_f1_reg <= '0;
      gate_sel_reg <= '0;
      stg_ctrl_reg <= '0;
      stg_num_reg <= `ISFG_RST_CYC_NUM;
      stg_den_reg <= `ISFG_RST_CYC_DEN;
      stg_ext_reg <= '0;
      stg_bs_reg <= '0;
      stg_bns_reg <= '0;
      stg_gcl_reg <= '{default: '0};
    end
    else if (wr_stb)
    begin
      case (wb_adr_i)
        `ISFG_OFS_FILT_DATA0: stg_f0_reg <= merge(stg_f0_reg, wb_dat_i, wb_sel_i);
        `ISFG_OFS_FILT_DATA1: stg_f1_reg <= merge(stg_f1_reg, wb_dat_i, wb_sel_i) &
          32'h0000_01FF;
        `ISFG_OFS_GATE_SEL: gate_sel_reg <= wb_sel_i[0] ? wb_dat_i[3:0] : gate_sel_reg;
        `ISFG_OFS_GATE_CTRL: stg_ctrl_reg <= wb_sel_i[0] ? wb_dat_i[7:0] : stg_ctrl_reg;
        `ISFG_OFS_GATE_CYC_NUM: stg_num_reg <= merge(stg_num_reg, wb_dat_i, wb_sel_i);
        `ISFG_OFS_GATE_CYC_DEN: stg_den_reg <= merge(stg_den_reg, wb_dat_i, wb_sel_i);
        `ISFG_OFS_GATE_CYC_EXT: stg_ext_reg <= merge(stg_ext_reg, wb_dat_i, wb_sel_i);
        `ISFG_OFS_GATE_BASE_S: stg_bs_reg <= merge(stg_bs_reg, wb_dat_i, wb_sel_i);
        `ISFG_OFS_GATE_BASE_NS: stg_bns_reg <= merge(stg_bns_reg, wb_dat_i, wb_sel_i);
        default:
        begin
          if (wb_adr_i[7:5] == `ISFG_GCL_BASE_HI)
          begin
            stg_gcl_reg[wb_adr_i[4:3]][wb_adr_i[2]] <= merge(stg_gcl_reg[wb_adr_i[4:3]][wb_adr_i[2]],
              wb_dat_i, wb_sel_i) & (wb_adr_i[2] ? 32'h003F_FFFF : 32'hFFFF_FFFF);
          end
        end
      endcase
    end
  end

  // Filter table: one entry per handle, each its own combination of gate and meter
  isfg_filter_mem u_filter_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_en_i(filt_wr),
    .wr_addr_i(wb_dat_i[4:0]),
    .wr_data_i({stg_f1_reg[`ISFG_FILT_DATA1_BITS-1:0], stg_f0_reg}),
    .rd_en_i(frame_valid_i && frame_ready_o),
    .rd_addr_i(frame_handle_i),
    .rd_data_o(filt_rd)
  );

  // Written-entry flags and blocked latches; a new block wins over a clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      valid_reg <= '0;
      blocked_reg <= '0;
    end
    else
    begin
      if (filt_wr)
      begin
        valid_reg[wb_dat_i[4:0]] <= 1'b1;
      end
      blocked_reg <= (blocked_reg & ~clear_mask) | (block_set ? (32'h0000_0001 << fr_handle_reg) : '0);
    end
  end

  // Frame descriptor sequencer
  assign frame_ready_o = (state_reg == isfg_pkg::ISFG_IDLE);
  always_comb
  begin
    case (state_reg)
      isfg_pkg::ISFG_IDLE: state_next = frame_valid_i ? isfg_pkg::ISFG_FETCH : isfg_pkg::ISFG_IDLE;
      isfg_pkg::ISFG_FETCH: state_next = isfg_pkg::ISFG_JUDGE;
      default: state_next = isfg_pkg::ISFG_IDLE;
    endcase
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= isfg_pkg::ISFG_IDLE;
      {fr_ct_reg, fr_hit_reg, fr_port_reg, fr_pcp_reg, fr_handle_reg, fr_len_reg} <= '0;
    end
    else
    begin
      state_reg <= state_next;
      if (frame_valid_i && frame_ready_o)
      begin
        {fr_ct_reg, fr_hit_reg, fr_port_reg} <= {frame_cut_through_i, frame_stream_hit_i, frame_port_i};
        {fr_pcp_reg, fr_handle_reg, fr_len_reg} <= {frame_pcp_i, frame_handle_i, frame_len_i};
      end
    end
  end

  // Filter match, size check and gate state for the frame under judgement
  assign judge_en = (state_reg == isfg_pkg::ISFG_JUDGE);
  assign matched = !fr_ct_reg && fr_hit_reg && valid_reg[fr_handle_reg] && filt_rd.port_map[fr_port_reg] &&
    ((filt_rd.prio_spec == `ISFG_PRIO_WILDCARD) || (filt_rd.prio_spec == {5'h00, fr_pcp_reg}));
  assign oversize = fr_len_reg > filt_rd.max_frame_size_limit;
  assign gid = filt_rd.gate_id;
  assign cur_cfg = gate_cfg_reg[gid];
  assign cur_gcl = gcl_reg[gid][ent_reg[gid]];
  assign sched = run_reg[gid];
  assign gate_on = matched && filt_rd.use_gate && cur_cfg.en;
  assign g_open = !closed_reg[gid] && (sched ? cur_gcl.open : cur_cfg.adm_open);
  assign oct_short = sched && cur_gcl.oct_en && ({2'h0, fr_len_reg} >= budget_reg[gid]);
  always_comb
  begin
    if (!matched)
      reason = isfg_pkg::ISFG_PASS;
    else if (blocked_reg[fr_handle_reg])
      reason = isfg_pkg::ISFG_BLOCKED;
    else if (oversize)
      reason = isfg_pkg::ISFG_OVERSIZE;
    else if (gate_on && !g_open)
      reason = isfg_pkg::ISFG_GATE_CLOSED;
    else if (gate_on && oct_short)
      reason = isfg_pkg::ISFG_NO_OCTETS;
    else
      reason = isfg_pkg::ISFG_PASS;
  end
  assign block_set = judge_en && (reason == isfg_pkg::ISFG_OVERSIZE) && filt_rd.block_en;
  assign charge = judge_en && (reason == isfg_pkg::ISFG_PASS) && gate_on && sched && cur_gcl.oct_en;
  assign latch_close = judge_en && (((reason == isfg_pkg::ISFG_GATE_CLOSED) && cur_cfg.cir_en) ||
    ((reason == isfg_pkg::ISFG_NO_OCTETS) && cur_cfg.coe_en));
  // Class from gate priority, else admin priority, else frame priority
  assign tc_sel = (gate_on && sched && cur_gcl.int_prio[3]) ? cur_gcl.int_prio[2:0] :
    (gate_on && cur_cfg.adm_int_prio[3]) ? cur_cfg.adm_int_prio[2:0] : fr_pcp_reg;

  // Verdict registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      {verdict_valid_o, verdict_pass_o, verdict_reason_o, verdict_tc_o} <= '0;
      {verdict_meter_use_o, verdict_meter_id_o} <= '0;
    end
    else
    begin
      verdict_valid_o <= judge_en;
      if (judge_en)
      begin
        verdict_pass_o <= (reason == isfg_pkg::ISFG_PASS);
        verdict_reason_o <= reason;
        verdict_tc_o <= tc_sel;
        verdict_meter_use_o <= matched && filt_rd.use_meter && filt_rd.meter_en;
        verdict_meter_id_o <= filt_rd.meter_id;
      end
    end
  end

  // Schedule stepping and switch conditions for each gate
  assign base_due = time_reached(pend_bs_reg, pend_bns_reg);
  always_comb
  begin
    for (int g = 0; g < NG; g++)
    begin
      cyc_end[g] = (pos_reg[g] + `ISFG_CLK_PERIOD_NS) >= cycle_reg[g];
      ent_adv[g] = ((ent_ns_reg[g] + `ISFG_CLK_PERIOD_NS) >= gcl_reg[g][ent_reg[g]].interval_ns) &&
        (ent_reg[g] != 2'h3);
      do_switch[g] = pend_reg && (pend_gate_reg == 4'(g)) && base_due &&
        (!run_reg[g] || cyc_end[g] || ((cycle_reg[g] - pos_reg[g]) > pend_ext_reg));
    end
  end

  // Pending schedule, held until its base time
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pend_reg <= 1'b0;
      pend_gate_reg <= '0;
      {pend_cycle_reg, pend_ext_reg, pend_bs_reg, pend_bns_reg} <= '0;
      pend_gcl_reg <= '{default: '0};
    end
    else if (apply_stb)
    begin
      pend_reg <= 1'b1;
      pend_gate_reg <= gate_sel_reg;
      {pend_cycle_reg, pend_ext_reg, pend_bs_reg, pend_bns_reg} <= {stg_num_reg, stg_ext_reg, stg_bs_reg, stg_bns_reg};
      for (int e = 0; e < `ISFG_NUM_GCL; e++)
      begin
        pend_gcl_reg[e] <= {stg_gcl_reg[e][1][`ISFG_GCL_WORD1_BITS-1:0], stg_gcl_reg[e][0]};
      end
    end
    else if (|do_switch)
    begin
      pend_reg <= 1'b0;
    end
  end

  // Operating gate state, cycle position, entry and octet budget
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gate_cfg_reg <= '{default: '0};
      gcl_reg <= '{default: '0};
      cycle_reg <= '{default: `ISFG_RST_CYC_NUM};
      pos_reg <= '{default: '0};
      ent_ns_reg <= '{default: '0};
      ent_reg <= '{default: '0};
      budget_reg <= '{default: '0};
      run_reg <= '0;
      closed_reg <= '0;
    end
    else
    begin
      for (int g = 0; g < NG; g++)
      begin
        if (do_switch[g])
        begin
          gcl_reg[g] <= pend_gcl_reg;
          cycle_reg[g] <= pend_cycle_reg;
          run_reg[g] <= 1'b1;
          pos_reg[g] <= '0;
          ent_reg[g] <= 2'h0;
          ent_ns_reg[g] <= '0;
          budget_reg[g] <= pend_gcl_reg[0].oct_max;
        end
        else if (run_reg[g] && cyc_end[g])
        begin
          pos_reg[g] <= '0;
          ent_reg[g] <= 2'h0;
          ent_ns_reg[g] <= '0;
          budget_reg[g] <= gcl_reg[g][0].oct_max;
        end
        else if (run_reg[g])
        begin
          pos_reg[g] <= pos_reg[g] + `ISFG_CLK_PERIOD_NS;
          if (ent_adv[g])
          begin
            ent_reg[g] <= 2'(ent_reg[g] + 2'h1);
            ent_ns_reg[g] <= '0;
            budget_reg[g] <= gcl_reg[g][2'(ent_reg[g] + 2'h1)].oct_max;
          end
          else
          begin
            ent_ns_reg[g] <= ent_ns_reg[g] + `ISFG_CLK_PERIOD_NS;
            if (charge && (gid == 4'(g)))
            begin
              budget_reg[g] <= budget_reg[g] - {2'h0, fr_len_reg};
            end
          end
        end
        if (latch_close && (gid == 4'(g)))
        begin
          closed_reg[g] <= 1'b1;
        end
        else if (apply_stb && (gate_sel_reg == 4'(g)))
        begin
          closed_reg[g] <= 1'b0;
        end
        if (apply_stb && (gate_sel_reg == 4'(g)))
        begin
          gate_cfg_reg[g] <= stg_ctrl_reg;
        end
      end
    end
  end

  sequence accept_s;
    frame_valid_i && frame_ready_o;
  endsequence
  sequence verdict_s;
    !verdict_valid_o [*2] ##1 verdict_valid_o;
  endsequence
  verdict_latency_a: assert property (accept_s |=> verdict_s) else $error("verdict not on third cycle");
  ct_bypass_a: assert property (judge_en && fr_ct_reg |=> verdict_pass_o && (verdict_tc_o == $past(fr_pcp_reg)))
    else $error("cut-through frame was policed");
  oversize_drop_a: assert property (judge_en && matched && !blocked_reg[fr_handle_reg] && oversize
    |=> !verdict_pass_o && (verdict_reason_o == isfg_pkg::ISFG_OVERSIZE)) else $error("oversize passed");
  block_latch_a: assert property (block_set |=> blocked_reg[$past(fr_handle_reg)])
    else $error("stream not blocked");
  clear_block_a: assert property (clear_mask[0] && !(block_set && fr_handle_reg == 5'h00) |=> !blocked_reg[0])
    else $error("blocked stream not cleared");
  port_map_a: assert property (judge_en && !filt_rd.port_map[fr_port_reg] |=> verdict_pass_o)
    else $error("filter acted on unmapped port");
  gate_closed_a: assert property (judge_en && gate_on && !g_open && !blocked_reg[fr_handle_reg] && !oversize
    |=> verdict_reason_o == isfg_pkg::ISFG_GATE_CLOSED) else $error("closed gate passed frame");
  closed_latch_a: assert property (latch_close |=> closed_reg[$past(gid)])
    else $error("gate did not latch closed");
  apply_only_a: assert property (!apply_stb |=> $stable(gate_cfg_reg[0]))
    else $error("gate parameters changed without config change");
  entry_order_a: assert property (run_reg[0] && $changed(ent_reg[0]) |->
    (ent_reg[0] == 2'h0) || (ent_reg[0] == 2'($past(ent_reg[0]) + 2'h1))) else $error("entry out of order");
endmodule

/* hdl/isfg_defs.svh */
// Register offsets, field positions, reset values and timing of the ingress stream filter gate
`ifndef ISFG_DEFS_SVH
`define ISFG_DEFS_SVH
`define ISFG_CLK_PERIOD_NS 32'h0000_0005
`define ISFG_NUM_FILTERS 32
`define ISFG_NUM_GATES 16
`define ISFG_NUM_GCL 4
`define ISFG_NUM_METERS 8
`define ISFG_OFS_FILT_DATA0 8'h00
`define ISFG_OFS_FILT_DATA1 8'h04
`define ISFG_OFS_FILT_CMD 8'h08
`define ISFG_OFS_FILT_BLOCKED 8'h0C
`define ISFG_OFS_GATE_SEL 8'h10
`define ISFG_OFS_GATE_CTRL 8'h14
`define ISFG_OFS_GATE_CYC_NUM 8'h18
`define ISFG_OFS_GATE_CYC_DEN 8'h1C
`define ISFG_OFS_GATE_CYC_EXT 8'h20
`define ISFG_OFS_GATE_BASE_S 8'h24
`define ISFG_OFS_GATE_BASE_NS 8'h28
`define ISFG_OFS_GATE_APPLY 8'h2C
`define ISFG_OFS_GATE_STATUS 8'h30
`define ISFG_GCL_BASE_HI 3'h2
`define ISFG_CMD_WRITE_BIT 8
`define ISFG_APPLY_BIT 0
`define ISFG_FILT_DATA1_BITS 9
`define ISFG_GCL_WORD1_BITS 22
`define ISFG_PRIO_WILDCARD 8'hFF
`define ISFG_RST_CYC_NUM 32'h000F_4240
`define ISFG_RST_CYC_DEN 32'h3B9A_CA00
`endif

/* hdl/isfg_pkg.sv */
// Types of the ingress stream filter gate
package isfg_pkg;
  typedef enum logic [1:0] {ISFG_IDLE = 2'b00, ISFG_FETCH = 2'b01, ISFG_JUDGE = 2'b11} isfg_state_t;
  typedef enum logic [2:0] {
    ISFG_PASS = 3'h0,
    ISFG_BLOCKED = 3'h1,
    ISFG_OVERSIZE = 3'h2,
    ISFG_GATE_CLOSED = 3'h3,
    ISFG_NO_OCTETS = 3'h4
  } isfg_reason_t;
  typedef struct packed {
    logic meter_en;
    logic [2:0] meter_id;
    logic use_meter;
    logic [3:0] gate_id;
    logic use_gate;
    logic block_en;
    logic [13:0] max_frame_size_limit;
    logic [7:0] prio_spec;
    logic [7:0] port_map;
  } isfg_filt_t;
  typedef struct packed {
    logic [15:0] oct_max;
    logic oct_en;
    logic [3:0] int_prio;
    logic open;
    logic [31:0] interval_ns;
  } isfg_gcl_t;
  typedef struct packed {
    logic coe_en;
    logic cir_en;
    logic [3:0] adm_int_prio;
    logic adm_open;
    logic en;
  } isfg_gate_cfg_t;
endpackage

/* hdl/isfg_filter_mem.sv */
// Stream filter table memory with registered read data
`timescale 1ns/100ps
`include "isfg_defs.svh"
module isfg_filter_mem (
  input wire logic clk_i, // Core clock
  input wire logic rst_i, // Synchronous reset
  input wire logic wr_en_i, // Write strobe
  input wire logic [4:0] wr_addr_i, // Write index
  input isfg_pkg::isfg_filt_t wr_data_i, // Write entry
  input wire logic rd_en_i, // Read strobe
  input wire logic [4:0] rd_addr_i, // Read index
  output isfg_pkg::isfg_filt_t rd_data_o // Read entry, registered
);
  isfg_pkg::isfg_filt_t mem_reg [`ISFG_NUM_FILTERS];

  // Table write port
  always_ff @(posedge clk_i)
  begin
    if (wr_en_i)
    begin
      mem_reg[wr_addr_i] <= wr_data_i;
    end
  end

  // Registered read port
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_data_o <= '0;
    end
    else if (rd_en_i)
    begin
      rd_data_o <= mem_reg[rd_addr_i];
    end
  end
endmodule

/* verification/isfg_ingress_model.sv */
// Ingress port and lookup model offering frame descriptors
`timescale 1ns/100ps
module isfg_ingress_model (
  input wire logic clk_i, // Core clock
  input wire logic ready_i, // Descriptor taken
  output logic valid_o, // Descriptor valid
  output logic [2:0] port_o, // Ingress port
  output logic cut_o, // Cut-through flag
  output logic hit_o, // Lookup hit
  output logic [4:0] handle_o, // Stream handle
  output logic [2:0] pcp_o, // Priority code point
  output logic [13:0] len_o // Frame length
);
  // Idle at time zero
  initial
  begin
    valid_o = 1'b0;
    {port_o, cut_o, hit_o, handle_o, pcp_o, len_o} = '0;
  end
  // Hold one descriptor until taken, then scramble the stale fields
  task automatic send(input logic [2:0] p, input logic c, input logic h, input logic [4:0] hd,
                      input logic [2:0] pc, input logic [13:0] l);
    @(posedge clk_i);
    valid_o <= 1'b1;
    {port_o, cut_o, hit_o, handle_o, pcp_o, len_o} <= {p, c, h, hd, pc, l};
    do @(posedge clk_i); while (ready_i !== 1'b1);
    valid_o <= 1'b0;
    {port_o, cut_o, hit_o, handle_o, pcp_o, len_o} <= ~{p, c, h, hd, pc, l};
  endtask
endmodule

/* verification/isfg_top_tb.sv */
// Self-checking testbench of the ingress stream filter gate
`timescale 1ns/100ps
`include "isfg_defs.svh"
module isfg_top_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o, rd;
  logic wb_ack_o, frame_valid_i, frame_ready_o, frame_cut_through_i, frame_stream_hit_i;
  logic [2:0] frame_port_i, frame_pcp_i, verdict_reason_o, verdict_tc_o, verdict_meter_id_o;
  logic [4:0] frame_handle_i;
  logic [13:0] frame_len_i;
  logic verdict_valid_o, verdict_pass_o, verdict_meter_use_o;
  logic [31:0] port_schedule_timer_sec_i = 32'h0000_0000;
  logic [29:0] port_schedule_timer_ns_i = 30'h0000_0000;
  int errors = 0;
  int n_compared = 0;
  isfg_top i_isfg_top (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .frame_valid_i, .frame_ready_o, .frame_port_i, .frame_cut_through_i,
    .frame_stream_hit_i, .frame_handle_i, .frame_pcp_i, .frame_len_i,
    .port_schedule_timer_sec_i, .port_schedule_timer_ns_i,
    .verdict_valid_o, .verdict_pass_o, .verdict_reason_o, .verdict_tc_o, .verdict_meter_use_o,
    .verdict_meter_id_o);
  isfg_ingress_model i_isfg_ingress_model (.clk_i, .ready_i(frame_ready_o), .valid_o(frame_valid_i),
    .port_o(frame_port_i), .cut_o(frame_cut_through_i), .hit_o(frame_stream_hit_i),
    .handle_o(frame_handle_i), .pcp_o(frame_pcp_i), .len_o(frame_len_i));
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Print counts and verdict, end the run
  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Classic single Wishbone cycle, held until ack
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} <= {2'b11, we, 4'hF, adr, dat};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask
  // One descriptor; compares {valid, pass, reason, tc, meter use}
  task automatic frame(input logic [2:0] p, input logic c, input logic [4:0] hd, input logic [2:0] pc,
                       input logic [13:0] l, input logic [7:0] exp);
    int n;
    i_isfg_ingress_model.send(p, c, 1'b1, hd, pc, l);
    n = 0;
    while (verdict_valid_o !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    chk({verdict_valid_o, verdict_pass_o, verdict_reason_o, verdict_tc_o, verdict_meter_use_o}, {1'b1, exp});
  endtask
  task automatic t_regs();
    wb(1'b0, `ISFG_OFS_GATE_CYC_NUM, 32'h0000_0000);
    chk(rd, 32'h000F_4240);
    wb(1'b0, `ISFG_OFS_GATE_CYC_DEN, 32'h0000_0000);
    chk(rd, 32'h3B9A_CA00);
    $display("Register defaults done");
  endtask
  task automatic t_filter();
    frame(3'd0, 1'b0, 5'd5, 3'd2, 14'd60, 8'h84);
    wb(1'b1, `ISFG_OFS_FILT_DATA0, 32'h4064_0301);
    wb(1'b1, `ISFG_OFS_FILT_DATA1, 32'h0000_01B0);
    wb(1'b1, `ISFG_OFS_FILT_CMD, 32'h0000_0100);
    frame(3'd0, 1'b0, 5'd0, 3'd3, 14'd100, 8'h87);
    chk({29'h0, verdict_meter_id_o}, 32'h0000_0005);
    frame(3'd0, 1'b0, 5'd0, 3'd4, 14'd50, 8'h88);
    frame(3'd1, 1'b0, 5'd0, 3'd3, 14'd50, 8'h86);
    frame(3'd0, 1'b1, 5'd0, 3'd3, 14'd200, 8'h86);
    $display("Filter match done");
  endtask
  task automatic t_block();
    frame(3'd0, 1'b0, 5'd0, 3'd3, 14'd101, 8'h27);
    frame(3'd0, 1'b0, 5'd0, 3'd3, 14'd50, 8'h17);
    wb(1'b0, `ISFG_OFS_FILT_BLOCKED, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    wb(1'b1, `ISFG_OFS_FILT_BLOCKED, 32'h0000_0001);
    wb(1'b0, `ISFG_OFS_FILT_BLOCKED, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    frame(3'd0, 1'b0, 5'd0, 3'd3, 14'd50, 8'h87);
    $display("Stream block done");
  endtask
  task automatic t_gate();
    wb(1'b1, `ISFG_OFS_FILT_DATA0, 32'h83E8_FFFF);
    wb(1'b1, `ISFG_OFS_FILT_DATA1, 32'h0000_0000);
    wb(1'b1, `ISFG_OFS_FILT_CMD, 32'h0000_0101);
    frame(3'd2, 1'b0, 5'd1, 3'd5, 14'd60, 8'h8A);
    wb(1'b1, `ISFG_OFS_GATE_SEL, 32'h0000_0000);
    wb(1'b1, `ISFG_OFS_GATE_BASE_S, 32'h0000_0001);
    wb(1'b1, `ISFG_OFS_GATE_CTRL, 32'h0000_0001);
    frame(3'd2, 1'b0, 5'd1, 3'd5, 14'd60, 8'h8A);
    wb(1'b1, `ISFG_OFS_GATE_APPLY, 32'h0000_0001);
    wb(1'b0, `ISFG_OFS_GATE_APPLY, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    frame(3'd2, 1'b0, 5'd1, 3'd5, 14'd60, 8'h3A);
    wb(1'b1, `ISFG_OFS_GATE_CTRL, 32'h0000_003B);
    wb(1'b1, `ISFG_OFS_GATE_APPLY, 32'h0000_0001);
    frame(3'd2, 1'b0, 5'd1, 3'd5, 14'd60, 8'h8C);
    $display("Stream gate done");
  endtask
  // Schedule waits for base time, then class override and octet budget
  task automatic t_sched();
    wb(1'b1, 8'h40, 32'h0000_4000); // Entry 0 interval in ns
    wb(1'b1, 8'h44, 32'h0000_1935); // Entry 0: 100 octets, limit on, class 2, open
    wb(1'b1, `ISFG_OFS_GATE_CTRL, 32'h0000_0083);
    wb(1'b1, `ISFG_OFS_GATE_APPLY, 32'h0000_0001);
    frame(3'd2, 1'b0, 5'd1, 3'd5, 14'd60, 8'h8A);
    wb(1'b0, `ISFG_OFS_GATE_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    @(posedge clk_i);
    port_schedule_timer_sec_i <= 32'h0000_0001;
    wb(1'b0, `ISFG_OFS_GATE_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    frame(3'd2, 1'b0, 5'd1, 3'd5, 14'd60, 8'h84);
    frame(3'd2, 1'b0, 5'd1, 3'd5, 14'd60, 8'h44);
    frame(3'd2, 1'b0, 5'd1, 3'd5, 14'd10, 8'h34);
    wb(1'b0, `ISFG_OFS_GATE_APPLY, 32'h0000_0000);
    chk(rd, 32'h0001_0000);
    $display("Gate schedule done");
  endtask
  // 200 MHz clock
  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end
  // Watchdog
  initial
  begin
    #100000;
    errors++;
    conclude();
  end
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_filter();
    t_block();
    t_gate();
    t_sched();
    conclude();
  end
endmodule
